// >>> design/omrg_gate.sv
`timescale 1ns/10ps
// Summary of operation
// - direction item shows forward/reverse; inc or dec flips it on display update
// - direction may change any time, even while running
// - control source item shows remote/local; inc or dec toggles it
// - keypad changes control source only while stopped; always displayed
// - when a terminal owns control source, keypad changes are ignored
// - run ignored on control source item; needs release, green item, reassert
// - run ignored on parameter item; needs release, green item, reassert
// - enter shows data, edits flash, second enter stores, number returns after 1 s
// - mode key during data edit discards value, shows number again
// - run-locked parameters keep data while running
// - green items mean drive mode; red items drive if running else program
// - once stopped in program mode, no start until drive mode again
// - power-up selects the frequency reference item
// - write-prohibit setting 5 accepts run as in drive mode on red items
// - write-prohibit setting resets to 1
// - run refused while the write-prohibit setting is being edited
// - run-lock attribute per parameter, independent of write-prohibit setting
module omrg_gate
	import omrg_pkg::*;
#(
	parameter int HOLD_CNT = omrg_pkg::HOLD_CYCLES
) (
	input  wire logic                          ref_clk,
	input  wire logic                          rst_n,
	input  wire logic                          mode_key,
	input  wire logic                          inc_key,
	input  wire logic                          dec_key,
	input  wire logic                          enter_key,
	input  wire logic                          run_cmd,
	input  wire logic                          drive_running,
	input  wire logic                          src_on_terminal,
	input  wire logic                          terminal_src_sel,
	input  wire logic                          param_run_locked,
	input  wire logic [omrg_pkg::PDATA_W-1:0]  param_data_in,
	output logic      [6:0]                    item_leds,
	output logic                               drive_mode,
	output logic                               run_accept,
	output logic                               dir_reverse,
	output logic                               src_local,
	output logic      [omrg_pkg::PNUM_W-1:0]   param_num,
	output logic      [omrg_pkg::PDATA_W-1:0]  param_edit_data,
	output logic                               show_data,
	output logic                               data_flash,
	output logic                               param_store,
	output logic      [omrg_pkg::PDATA_W-1:0]  write_prohibit_init_setting
);
	import omrg_pkg::*;

	omrg_key_if keys ();
	logic       hold_done;
	logic       hold_start;
	logic       hold_cancel;

	omrg_key_edge u_keys (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.mode_key  (mode_key),
		.inc_key   (inc_key),
		.dec_key   (dec_key),
		.enter_key (enter_key),
		.keys      (keys)
	);

	omrg_hold_timer #(.CYCLES(HOLD_CNT)) u_hold (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.start   (hold_start),
		.cancel  (hold_cancel),
		.done    (hold_done)
	);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	omrg_item_type        item_q, item_d;
	omrg_edit_type        edit_q, edit_d;
	logic                 dir_q, dir_d;
	logic                 src_q, src_d;
	logic [PNUM_W-1:0]    pnum_q, pnum_d;
	logic [PDATA_W-1:0]   pdata_q, pdata_d;
	logic [PDATA_W-1:0]   wp_q, wp_d;
	logic                 blocked_q, blocked_d;
	logic                 prog_stop_q, prog_stop_d;
	logic                 accept_q, accept_d;
	logic                 dmode_q, dmode_d;
	logic                 store_q, store_d;
	logic                 show_q, show_d;
	logic                 flash_q, flash_d;
	logic                 red_item;
	logic                 editing_wp;

	function automatic omrg_item_type next_item(input omrg_item_type cur);
		case (cur)
			ITEM_FREQ_REFERENCE_ITEM_ST: next_item = ITEM_OUTPUT_FREQ_ITEM_ST;
			ITEM_OUTPUT_FREQ_ITEM_ST: next_item = ITEM_OUTPUT_CURRENT_ITEM_ST;
			ITEM_OUTPUT_CURRENT_ITEM_ST: next_item = ITEM_MULTI_MONITOR_ITEM_ST;
			ITEM_MULTI_MONITOR_ITEM_ST: next_item = ITEM_DIR_ST;
			ITEM_DIR_ST:  next_item = ITEM_SRC_ST;
			ITEM_SRC_ST:  next_item = ITEM_PARAM_SETTING_ITEM_ST;
			default:      next_item = ITEM_FREQ_REFERENCE_ITEM_ST;
		endcase
	endfunction

	always_comb begin
		red_item   = (item_q == ITEM_SRC_ST) || (item_q == ITEM_PARAM_SETTING_ITEM_ST);
		editing_wp = (item_q == ITEM_PARAM_SETTING_ITEM_ST) && (pnum_q == WP_PARAM_NUM)
			&& (edit_q != ED_NUM_ST);
	end

	// ------------------------------------------------------------
	// item and edit sequencing
	// ------------------------------------------------------------
	always_comb begin
		item_d      = item_q;
		edit_d      = edit_q;
		dir_d       = dir_q;
		src_d       = src_on_terminal ? terminal_src_sel : src_q;
		pnum_d      = pnum_q;
		pdata_d     = pdata_q;
		wp_d        = wp_q;
		store_d     = 1'b0;
		hold_start  = 1'b0;
		hold_cancel = 1'b0;
		if (keys.mode_p) begin
			if (edit_q == ED_FLASH_ST || edit_q == ED_DATA_ST) begin
				edit_d      = ED_NUM_ST;
			end else begin
				item_d      = next_item(item_q);
				edit_d      = ED_NUM_ST;
				hold_cancel = 1'b1;
			end
		end else begin
			case (item_q)
				ITEM_DIR_ST: begin
					if (keys.inc_p || keys.dec_p) begin
						dir_d = ~dir_q;
					end
				end
				ITEM_SRC_ST: begin
					if ((keys.inc_p || keys.dec_p) && !drive_running
						&& !src_on_terminal) begin
						src_d = ~src_q;
					end
				end
				ITEM_PARAM_SETTING_ITEM_ST: begin
					case (edit_q)
						ED_NUM_ST: begin
							if (keys.inc_p) begin
								pnum_d = pnum_q + 8'h01;
							end else if (keys.dec_p) begin
								pnum_d = pnum_q - 8'h01;
							end else if (keys.enter_p) begin
								edit_d  = ED_DATA_ST;
								pdata_d = (pnum_q == WP_PARAM_NUM) ? wp_q : param_data_in;
							end
						end
						ED_DATA_ST, ED_FLASH_ST: begin
							if ((keys.inc_p || keys.dec_p)
								&& !(param_run_locked && drive_running)) begin
								pdata_d = keys.inc_p ? pdata_q + 16'h0001
									: pdata_q - 16'h0001;
								edit_d  = ED_FLASH_ST;
							end else if (keys.enter_p && edit_q == ED_FLASH_ST) begin
								edit_d     = ED_STORED_ST;
								store_d    = 1'b1;
								hold_start = 1'b1;
								if (pnum_q == WP_PARAM_NUM) begin
									wp_d = pdata_q;
								end
							end
						end
						ED_STORED_ST: begin
							if (hold_done) begin
								edit_d = ED_NUM_ST;
							end
						end
						default: edit_d = ED_NUM_ST;
					endcase
				end
				default: ;
			endcase
		end
		// display flags registered so the pins come straight from flops
		show_d  = (edit_d != ED_NUM_ST);
		flash_d = (edit_d == ED_FLASH_ST);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			item_q  <= ITEM_FREQ_REFERENCE_ITEM_ST;
			edit_q  <= ED_NUM_ST;
			dir_q   <= DIR_FWD;
			src_q   <= SRC_REMOTE;
			pnum_q  <= '0;
			pdata_q <= '0;
			wp_q    <= WP_RESET_VAL;
			store_q <= 1'b0;
			show_q  <= 1'b0;
			flash_q <= 1'b0;
		end else begin
			item_q  <= item_d;
			edit_q  <= edit_d;
			dir_q   <= dir_d;
			src_q   <= src_d;
			pnum_q  <= pnum_d;
			pdata_q <= pdata_d;
			wp_q    <= wp_d;
			store_q <= store_d;
			show_q  <= show_d;
			flash_q <= flash_d;
		end
	end

	// ------------------------------------------------------------
	// run acceptance
	// ------------------------------------------------------------
	// a blocked run stays blocked until released on a green item, so a
	// held run switch cannot start the motor just by leaving a red item
	always_comb begin
		dmode_d     = !red_item || drive_running
			|| (wp_q == WP_RUN_ANYWHERE);
		blocked_d   = blocked_q;
		prog_stop_d = prog_stop_q;
		if (red_item && wp_q != WP_RUN_ANYWHERE && run_cmd) begin
			blocked_d = 1'b1;
		end else if (!red_item && !run_cmd) begin
			blocked_d = 1'b0;
		end
		if (!dmode_d && !drive_running) begin
			prog_stop_d = 1'b1;
		end else if (!red_item) begin
			prog_stop_d = 1'b0;
		end
		accept_d = run_cmd && dmode_d && !blocked_d && !editing_wp
			&& !(prog_stop_d && red_item && wp_q != WP_RUN_ANYWHERE);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			blocked_q   <= 1'b0;
			prog_stop_q <= 1'b0;
			accept_q    <= 1'b0;
			dmode_q     <= 1'b1;
		end else begin
			blocked_q   <= blocked_d;
			prog_stop_q <= prog_stop_d;
			accept_q    <= accept_d;
			dmode_q     <= dmode_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_comb begin
		item_leds                   = item_q;
		drive_mode                  = dmode_q;
		run_accept                  = accept_q;
		dir_reverse                 = dir_q;
		src_local                   = src_q;
		param_num                   = pnum_q;
		param_edit_data             = pdata_q;
		show_data                   = show_q;
		data_flash                  = flash_q;
		param_store                 = store_q;
		write_prohibit_init_setting = wp_q;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_power_up_item: assert property (@(posedge ref_clk)
		$rose(rst_n) |-> item_leds == ITEM_FREQ_REFERENCE_ITEM_ST)
		else $error("item not frequency reference after reset");
	a_src_run_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(item_q == ITEM_SRC_ST && wp_q != WP_RUN_ANYWHERE) |=> !run_accept)
		else $error("run accepted on control source item");
	a_param_setting_item_run_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(item_q == ITEM_PARAM_SETTING_ITEM_ST && wp_q != WP_RUN_ANYWHERE && !drive_running)
		|=> !run_accept)
		else $error("run accepted on parameter item");
	a_src_hold_running: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(drive_running && !src_on_terminal) |=> $stable(src_local))
		else $error("control source changed while running");
	a_src_terminal: assert property (@(posedge ref_clk) disable iff (!rst_n)
		src_on_terminal |=> src_local == $past(terminal_src_sel))
		else $error("control source did not follow the terminal");
	a_dir_flip: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(item_q == ITEM_DIR_ST && keys.inc_p && !keys.mode_p) |=> dir_reverse != $past(dir_q))
		else $error("direction did not flip");
	a_locked_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
		((edit_q == ED_FLASH_ST || edit_q == ED_DATA_ST) && param_run_locked
			&& drive_running && !keys.mode_p)
		|=> $stable(param_edit_data))
		else $error("locked parameter data changed while running");
	a_cancel_edit: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(edit_q == ED_FLASH_ST && keys.mode_p) |=> !show_data && !param_store)
		else $error("mode key did not discard edit");
	a_wp_edit_refuse: assert property (@(posedge ref_clk) disable iff (!rst_n)
		editing_wp |=> !run_accept)
		else $error("run accepted while write-prohibit edited");
	a_green_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!red_item |=> drive_mode)
		else $error("green item not in drive mode");
	c_store: cover property (@(posedge ref_clk) disable iff (!rst_n) param_store);
	c_accept: cover property (@(posedge ref_clk) disable iff (!rst_n) run_accept);
	c_wrap: cover property (@(posedge ref_clk) disable iff (!rst_n)
		item_q == ITEM_PARAM_SETTING_ITEM_ST && keys.mode_p);
	c_src_flip: cover property (@(posedge ref_clk) disable iff (!rst_n) $changed(src_local));
endmodule // omrg_gate

// >>> design/omrg_pkg.sv
package omrg_pkg;
	// ------------------------------------------------------------
	// item indicators, one-hot
	// ------------------------------------------------------------
	typedef enum logic [6:0] {
		ITEM_FREQ_REFERENCE_ITEM_ST = 7'h01,
		ITEM_OUTPUT_FREQ_ITEM_ST = 7'h02,
		ITEM_OUTPUT_CURRENT_ITEM_ST = 7'h04,
		ITEM_MULTI_MONITOR_ITEM_ST = 7'h08,
		ITEM_DIR_ST  = 7'h10,
		ITEM_SRC_ST  = 7'h20,
		ITEM_PARAM_SETTING_ITEM_ST = 7'h40
	} omrg_item_type;

	// ------------------------------------------------------------
	// parameter edit phases, one-hot
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ED_NUM_ST    = 4'h1,
		ED_DATA_ST   = 4'h2,
		ED_FLASH_ST  = 4'h4,
		ED_STORED_ST = 4'h8
	} omrg_edit_type;

	// ------------------------------------------------------------
	// constants
	// ------------------------------------------------------------
	localparam int          CLK_HZ          = 40000000;
	localparam int          HOLD_MS         = 1000;
	localparam int          HOLD_CYCLES     = (CLK_HZ / 1000) * HOLD_MS;
	localparam int          PNUM_W          = 8;
	localparam int          PDATA_W         = 16;
	localparam logic [7:0]  WP_PARAM_NUM    = 8'h01;
	localparam logic [15:0] WP_RESET_VAL    = 16'h0001;
	localparam logic [15:0] WP_RUN_ANYWHERE = 16'h0005;
	localparam logic        DIR_FWD         = 1'b0;
	localparam logic        SRC_REMOTE      = 1'b0;
endpackage

// >>> design/omrg_key_if.sv
`timescale 1ns/10ps
interface omrg_key_if;
	logic mode_p;
	logic inc_p;
	logic dec_p;
	logic enter_p;
	modport src (output mode_p, output inc_p, output dec_p, output enter_p);
	modport dst (input mode_p, input inc_p, input dec_p, input enter_p);
endinterface

// >>> design/omrg_key_edge.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// key press edge detection
// ------------------------------------------------------------
module omrg_key_edge (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic mode_key,
	input  wire logic inc_key,
	input  wire logic dec_key,
	input  wire logic enter_key,
	omrg_key_if.src   keys
);
	logic [3:0] prev_q;
	logic [3:0] prev_d;
	logic [3:0] now_w;

	always_comb begin
		now_w  = {enter_key, dec_key, inc_key, mode_key};
		prev_d = now_w;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			prev_q <= 4'h0;
		end else begin
			prev_q <= prev_d;
		end
	end

	assign keys.mode_p  = now_w[0] & ~prev_q[0];
	assign keys.inc_p   = now_w[1] & ~prev_q[1];
	assign keys.dec_p   = now_w[2] & ~prev_q[2];
	assign keys.enter_p = now_w[3] & ~prev_q[3];
endmodule // omrg_key_edge

// >>> design/omrg_hold_timer.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// one-shot hold timer for the stored-data display
// ------------------------------------------------------------
module omrg_hold_timer #(
	parameter int CYCLES = 40000000
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic start,
	input  wire logic cancel,
	output logic      done
);
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic        done_d;

	always_comb begin
		cnt_d  = cnt_q;
		done_d = 1'b0;
		if (start) begin
			cnt_d = 32'(CYCLES);
		end else if (cancel) begin
			cnt_d = 32'h0;
		end else if (cnt_q != 32'h0) begin
			cnt_d = cnt_q - 32'h1;
			done_d = (cnt_q == 32'h1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cnt_q <= 32'h0;
			done  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			done  <= done_d;
		end
	end
endmodule // omrg_hold_timer

// >>> verification/omrg_keypad_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// operator keypad and run input model
// ------------------------------------------------------------
module omrg_keypad_model (
	input  wire logic ref_clk,
	output logic      mode_key,
	output logic      inc_key,
	output logic      dec_key,
	output logic      enter_key,
	output logic      run_cmd
);
	logic [3:0] keys_q = 4'h0;
	logic       run_q  = 1'h0;
	assign {enter_key, dec_key, inc_key, mode_key} = keys_q;
	assign run_cmd = run_q;
	// held two edges then released: one press per rising edge only
	task automatic press(input int k);
		@(posedge ref_clk) keys_q <= 4'h1 << k;
		repeat (2) @(posedge ref_clk);
		keys_q <= 4'h0;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
	// run must drop and rise again to be taken after a red item
	task automatic set_run(input logic v);
		@(posedge ref_clk) run_q <= v;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
endmodule // omrg_keypad_model

// >>> verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import omrg_pkg::*;
	// short hold keeps the run small
	localparam int HOLD = 20;
	logic        ref_clk, rst_n, mode_key, inc_key, dec_key, enter_key, run_cmd;
	logic        drive_running, src_on_terminal, terminal_src_sel, param_run_locked;
	logic [15:0] param_data_in, param_edit_data, write_prohibit_init_setting;
	logic [6:0]  item_leds;
	logic [7:0]  param_num;
	logic        drive_mode, run_accept, dir_reverse, src_local;
	logic        show_data, data_flash, param_store;
	int          err_count = 0;
	int          total_checks = 0;
	int          stores = 0;

	omrg_keypad_model kp (
		.ref_clk   (ref_clk),
		.mode_key  (mode_key),
		.inc_key   (inc_key),
		.dec_key   (dec_key),
		.enter_key (enter_key),
		.run_cmd   (run_cmd)
	);
	omrg_gate #(.HOLD_CNT(HOLD)) dut (
		.ref_clk                     (ref_clk),
		.rst_n                       (rst_n),
		.mode_key                    (mode_key),
		.inc_key                     (inc_key),
		.dec_key                     (dec_key),
		.enter_key                   (enter_key),
		.run_cmd                     (run_cmd),
		.drive_running               (drive_running),
		.src_on_terminal             (src_on_terminal),
		.terminal_src_sel            (terminal_src_sel),
		.param_run_locked            (param_run_locked),
		.param_data_in               (param_data_in),
		.item_leds                   (item_leds),
		.drive_mode                  (drive_mode),
		.run_accept                  (run_accept),
		.dir_reverse                 (dir_reverse),
		.src_local                   (src_local),
		.param_num                   (param_num),
		.param_edit_data             (param_edit_data),
		.show_data                   (show_data),
		.data_flash                  (data_flash),
		.param_store                 (param_store),
		.write_prohibit_init_setting (write_prohibit_init_setting)
	);

	initial begin
		ref_clk = 1'h0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) if (param_store === 1'h1) stores++;

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic mode_n(input int n);
		repeat (n) kp.press(0);
	endtask

	// bounded wait for the number display to come back
	task automatic wait_num;
		int i;
		for (i = 0; i < 200 && show_data !== 1'h0; i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (i == 200) begin
			err_count++;
			report_and_stop();
		end
		check("hold", (i >= HOLD - 10 && i <= HOLD + 2), 1'h1);
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		report_and_stop();
	end

	initial begin
		rst_n = 1'h0;
		drive_running = 1'h0;
		src_on_terminal = 1'h0;
		terminal_src_sel = 1'h0;
		param_run_locked = 1'h0;
		param_data_in = 16'h0001;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'h1;
		@(posedge ref_clk);
		#1;
		check("item", item_leds, 7'h01);
		check("wp", write_prohibit_init_setting, WP_RESET_VAL);
		for (int n = 1; n <= 7; n++) begin
			kp.press(0);
			check("item", item_leds, 7'h01 << (n % 7));
			check("drive", drive_mode, (n % 7) < 5);
		end
		// ------------------------------------------------------------
		// direction and control source
		// ------------------------------------------------------------
		mode_n(4);
		kp.press(1); check("dir", dir_reverse, 1'h1);
		@(posedge ref_clk) drive_running <= 1'h1;
		kp.press(2); check("dir", dir_reverse, 1'h0);
		kp.press(0);
		kp.press(1); check("src", src_local, 1'h0);
		check("drive", drive_mode, 1'h1);
		@(posedge ref_clk) drive_running <= 1'h0;
		kp.press(1); check("src", src_local, 1'h1);
		@(posedge ref_clk) src_on_terminal <= 1'h1;
		terminal_src_sel <= 1'h0;
		kp.press(2); check("src", src_local, 1'h0);
		@(posedge ref_clk) terminal_src_sel <= 1'h1;
		kp.press(1); check("src", src_local, 1'h1);
		@(posedge ref_clk) src_on_terminal <= 1'h0;
		// ------------------------------------------------------------
		// run gating on red items
		// ------------------------------------------------------------
		kp.set_run(1'h1); check("run", run_accept, 1'h0);
		kp.press(0); check("run", run_accept, 1'h0);
		check("drive", drive_mode, 1'h0);
		kp.press(0); check("run", run_accept, 1'h0);
		kp.set_run(1'h0);
		kp.set_run(1'h1); check("run", run_accept, 1'h1);
		kp.set_run(1'h0);
		// ------------------------------------------------------------
		// parameter edit
		// ------------------------------------------------------------
		mode_n(6);
		kp.press(1);
		kp.press(1); check("pnum", param_num, 8'h02);
		kp.press(3); check("show", show_data, 1'h1);
		kp.press(1); check("data", param_edit_data, 16'h0002);
		check("flash", data_flash, 1'h1);
		kp.press(3); check("flash", data_flash, 1'h0);
		check("store", stores, 16'h0001);
		wait_num();
		kp.press(3);
		kp.press(1);
		kp.press(0); check("show", show_data, 1'h0);
		check("store", stores, 16'h0001);
		check("item", item_leds, 7'h40);
		kp.press(3); check("data", param_edit_data, 16'h0001);
		kp.press(0);
		@(posedge ref_clk) drive_running <= 1'h1;
		param_run_locked <= 1'h1;
		param_data_in <= 16'h0030;
		kp.press(3);
		kp.press(1); check("data", param_edit_data, 16'h0030);
		kp.press(0);
		@(posedge ref_clk) drive_running <= 1'h0;
		param_run_locked <= 1'h0;
		// ------------------------------------------------------------
		// write-prohibit setting to run-anywhere
		// ------------------------------------------------------------
		kp.press(2);
		kp.press(3);
		repeat (4) kp.press(1);
		kp.press(3); check("wp", write_prohibit_init_setting, WP_RUN_ANYWHERE);
		wait_num();
		kp.press(1);
		kp.set_run(1'h1); check("run", run_accept, 1'h1);
		kp.press(2);
		kp.press(3); check("run", run_accept, 1'h0);
		kp.press(0);
		@(posedge ref_clk) drive_running <= 1'h1;
		param_run_locked <= 1'h1;
		param_data_in <= 16'h00A5;
		kp.press(1);
		kp.press(3);
		kp.press(1); check("data", param_edit_data, 16'h00A5);
		report_and_stop();
	end
endmodule // tb_top
